/* src/cabe_pkg.sv */
/*
 * constants for the execution unit: opcode classes, flag positions, cycle counts.
 * assumes a single 50 MHz system clock and a 16-bit word-addressed program counter.
 */
package cabe_pkg;
   typedef enum logic [4:0] {
      CABE_OP_NOP, CABE_OP_ADD, CABE_OP_ADC, CABE_OP_WADD, CABE_OP_SUB, CABE_OP_SBB,
      CABE_OP_WSUB, CABE_OP_AND, CABE_OP_BITWISE_CONJUNCTION_IMM, CABE_OP_OR, CABE_OP_ORI, CABE_OP_XOR,
      CABE_OP_SETM, CABE_OP_CLRM, CABE_OP_TST, CABE_OP_COM, CABE_OP_NEG, CABE_OP_POINTER_JUMP,
      CABE_OP_RELATIVE_BRANCH, CABE_OP_JMP, CABE_OP_RELATIVE_SUBROUTINE_ENTRY, CABE_OP_POINTER_SUBROUTINE_ENTRY, CABE_OP_CALL,
      CABE_OP_RET, CABE_OP_INTERRUPT_EXIT, CABE_OP_EQUAL_COMPARE_SKIP, CABE_OP_CPI, CABE_OP_SKBC
   } cabe_op_e;
   localparam int CABE_FLAG_C = 0;
   localparam int CABE_FLAG_Z = 1;
   localparam int CABE_FLAG_N = 2;
   localparam int CABE_FLAG_V = 3;
   localparam int CABE_FLAG_S = 4;
   localparam int CABE_FLAG_H = 5;
   localparam int CABE_FLAG_I = 7;
   localparam logic [7:0] CABE_SREG_RST = 8'h00;
   localparam logic [7:0] CABE_ALL_ONES = 8'hFF;
   localparam logic [15:0] CABE_PC_RST = 16'h0000;
   localparam logic [15:0] CABE_SP_RST = 16'h00FF;
   localparam logic [4:0] CABE_Z_LO = 5'h1E;
   localparam logic [4:0] CABE_Z_HI = 5'h1F;
   localparam logic [2:0] CABE_CYC_WORD = 3'h2;
   localparam logic [2:0] CABE_CYC_POINTER_JUMP = 3'h2;
   localparam logic [2:0] CABE_CYC_RELATIVE_BRANCH = 3'h2;
   localparam logic [2:0] CABE_CYC_JMP = 3'h3;
   localparam logic [2:0] CABE_CYC_RELATIVE_SUBROUTINE_ENTRY = 3'h4;
   localparam logic [2:0] CABE_CYC_POINTER_SUBROUTINE_ENTRY = 3'h4;
   localparam logic [2:0] CABE_CYC_CALL = 3'h5;
   localparam logic [2:0] CABE_CYC_RET = 3'h5;
endpackage

/* src/cabe_alu.sv */
/*
 * combinational 8-bit arithmetic and logic unit with flag generation.
 * assumes the caller decides which flags are written back.
 */
module cabe_alu
   import cabe_pkg::*;
(
   input wire cabe_op_e op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic carry_i,
   output logic [7:0] res_o,
   output logic [7:0] flags_o
);
   logic [8:0] wide;
   logic [4:0] half;
   logic sub;

   ////////////////////////////////////////////////////////////////////////////
   // result and flags; only arithmetic ops and COM produce carry, only arithmetic ops produce half carry
   always_comb begin
      wide = 9'h000;
      half = 5'h00;
      sub = 1'b0;
      res_o = 8'h00;
      flags_o = 8'h00;
      case (op_i)
         CABE_OP_ADD, CABE_OP_ADC: begin
            wide = {1'b0, a_i} + {1'b0, b_i} + {8'h00, carry_i & (op_i == CABE_OP_ADC)};
            half = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} +
                   {4'h0, carry_i & (op_i == CABE_OP_ADC)};
         end
         CABE_OP_SUB, CABE_OP_SBB, CABE_OP_CPI, CABE_OP_NEG: begin
            sub = 1'b1;
            wide = {1'b0, a_i} - {1'b0, b_i} - {8'h00, carry_i & (op_i == CABE_OP_SBB)};
            half = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} -
                   {4'h0, carry_i & (op_i == CABE_OP_SBB)};
         end
         CABE_OP_AND, CABE_OP_BITWISE_CONJUNCTION_IMM, CABE_OP_TST: wide = {1'b0, a_i & b_i};
         CABE_OP_OR, CABE_OP_ORI, CABE_OP_SETM: wide = {1'b0, a_i | b_i};
         CABE_OP_XOR: wide = {1'b0, a_i ^ b_i};
         CABE_OP_CLRM: wide = {1'b0, a_i & (CABE_ALL_ONES - b_i)};
         CABE_OP_COM: wide = {1'b1, CABE_ALL_ONES - a_i}; // carry is set
         default: wide = 9'h000;
      endcase
      res_o = wide[7:0];
      flags_o[CABE_FLAG_C] = wide[8];
      flags_o[CABE_FLAG_Z] = (wide[7:0] == 8'h00);
      flags_o[CABE_FLAG_N] = wide[7];
      flags_o[CABE_FLAG_H] = half[4];
      // overflow from operand signs; logic ops leave it zero
      if (op_i == CABE_OP_ADD || op_i == CABE_OP_ADC) begin
         flags_o[CABE_FLAG_V] = (a_i[7] == b_i[7]) && (wide[7] != a_i[7]);
      end else if (sub) begin
         flags_o[CABE_FLAG_V] = (a_i[7] != b_i[7]) && (wide[7] != a_i[7]);
      end
      flags_o[CABE_FLAG_S] = flags_o[CABE_FLAG_N] ^ flags_o[CABE_FLAG_V];
   end
endmodule

/* src/cabe_core.sv */
/*
 * execution unit: register file, status flags, program counter, stack, and
 * multi-cycle sequencing for the arithmetic, logic, jump, call and skip ops.
 * assumes a decoder on the same clock presents one instruction at a time with
 * exec_valid_i and waits for busy_o low; the stack lives in a local array.
 */
module cabe_core
   import cabe_pkg::*;
#(
   parameter int STACK_DEPTH = 256
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic exec_valid_i,
   input wire cabe_op_e exec_op_i,
   input wire logic [4:0] dst_sel_i,
   input wire logic [4:0] src_sel_i,
   input wire logic [7:0] imm_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [15:0] target_i,
   input wire logic next_is_long_i,
   output logic busy_o,
   output logic [15:0] pc_o,
   output logic [7:0] sreg_o,
   output logic [7:0] result_o
);
   // elaboration-time refusal of a stack the pointer cannot address
   if (STACK_DEPTH < 2 || STACK_DEPTH > 65536) begin : g_depth_check
      $error("STACK_DEPTH out of range");
   end

   logic rst_meta_reg, rst_sync_reg;
   logic [7:0] regs_reg [32];
   logic [7:0] regs_next [32];
   logic [15:0] stack_reg [STACK_DEPTH];
   logic [15:0] stack_next_val;
   logic stack_we;
   logic [15:0] sp_reg, sp_next;
   logic [15:0] pc_reg, pc_next;
   logic [7:0] sreg_reg, sreg_next;
   logic [7:0] result_reg, result_next;
   logic [2:0] wait_reg, wait_next;
   logic busy_reg, busy_next;
   logic [15:0] pend_pc_reg, pend_pc_next;
   logic [7:0] alu_res, alu_flags;
   logic [7:0] alu_a, alu_b;
   logic [15:0] word_op, word_sum;
   logic [15:0] z_ptr;
   logic [15:0] ret_addr;

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flops
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // operand selection: immediates feed b for the constant forms
   always_comb begin
      alu_a = regs_reg[dst_sel_i];
      alu_b = regs_reg[src_sel_i];
      case (exec_op_i)
         CABE_OP_BITWISE_CONJUNCTION_IMM, CABE_OP_ORI, CABE_OP_SETM, CABE_OP_CLRM, CABE_OP_CPI: alu_b = imm_i;
         CABE_OP_TST: alu_b = regs_reg[dst_sel_i];
         CABE_OP_NEG: begin
            alu_a = 8'h00;
            alu_b = regs_reg[dst_sel_i];
         end
         default: alu_b = regs_reg[src_sel_i];
      endcase
   end

   cabe_alu cabe_alu_inst (
      .op_i(exec_op_i),
      .a_i(alu_a),
      .b_i(alu_b),
      .carry_i(sreg_reg[CABE_FLAG_C]),
      .res_o(alu_res),
      .flags_o(alu_flags)
   );

   assign z_ptr = {regs_reg[CABE_Z_HI], regs_reg[CABE_Z_LO]};
   assign word_op = {regs_reg[dst_sel_i + 5'd1], regs_reg[dst_sel_i]};
   assign word_sum = (exec_op_i == CABE_OP_WSUB) ? word_op - {8'h00, imm_i} :
                                                   word_op + {8'h00, imm_i};
   assign ret_addr = pc_reg + 16'd1;

   ////////////////////////////////////////////////////////////////////////////
   // execute: a new op is taken only when idle; multi-cycle ops hold busy
   // and commit the new PC when the wait count runs out
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         regs_next[i] = regs_reg[i];
      end
      sreg_next = sreg_reg;
      pc_next = pc_reg;
      sp_next = sp_reg;
      result_next = result_reg;
      wait_next = wait_reg;
      busy_next = busy_reg;
      pend_pc_next = pend_pc_reg;
      stack_we = 1'b0;
      stack_next_val = ret_addr;
      if (busy_reg) begin
         wait_next = wait_reg - 3'd1;
         if (wait_reg == 3'd1) begin
            busy_next = 1'b0;
            pc_next = pend_pc_reg;
         end
      end else if (exec_valid_i) begin
         pend_pc_next = ret_addr;
         wait_next = 3'd0;
         case (exec_op_i)
            CABE_OP_ADD, CABE_OP_ADC, CABE_OP_SUB, CABE_OP_SBB, CABE_OP_NEG: begin
               regs_next[dst_sel_i] = alu_res;
               sreg_next[5:0] = alu_flags[5:0];
               result_next = alu_res;
            end
            CABE_OP_COM: begin
               regs_next[dst_sel_i] = alu_res;
               sreg_next[4:0] = alu_flags[4:0];
               result_next = alu_res;
            end
            CABE_OP_AND, CABE_OP_BITWISE_CONJUNCTION_IMM, CABE_OP_OR, CABE_OP_ORI, CABE_OP_XOR,
            CABE_OP_SETM, CABE_OP_CLRM, CABE_OP_TST: begin
               regs_next[dst_sel_i] = alu_res;
               sreg_next[CABE_FLAG_Z] = alu_flags[CABE_FLAG_Z];
               sreg_next[CABE_FLAG_N] = alu_flags[CABE_FLAG_N];
               sreg_next[CABE_FLAG_V] = 1'b0;
               sreg_next[CABE_FLAG_S] = alu_flags[CABE_FLAG_N];
               result_next = alu_res;
            end
            CABE_OP_CPI: begin
               sreg_next[5:0] = alu_flags[5:0]; // result not written to the register file
               result_next = alu_res;
            end
            CABE_OP_WADD, CABE_OP_WSUB: begin
               regs_next[dst_sel_i] = word_sum[7:0];
               regs_next[dst_sel_i + 5'd1] = word_sum[15:8];
               sreg_next[CABE_FLAG_Z] = (word_sum == 16'h0000);
               sreg_next[CABE_FLAG_N] = word_sum[15];
               if (exec_op_i == CABE_OP_WADD) begin
                  sreg_next[CABE_FLAG_C] = ~word_sum[15] & word_op[15];
                  sreg_next[CABE_FLAG_V] = ~word_op[15] & word_sum[15];
               end else begin
                  sreg_next[CABE_FLAG_C] = word_sum[15] & ~word_op[15];
                  sreg_next[CABE_FLAG_V] = word_op[15] & ~word_sum[15];
               end
               sreg_next[CABE_FLAG_S] = word_sum[15] ^ sreg_next[CABE_FLAG_V];
               result_next = word_sum[7:0];
               wait_next = CABE_CYC_WORD - 3'd1;
            end
            CABE_OP_POINTER_JUMP: begin
               pend_pc_next = z_ptr;
               wait_next = CABE_CYC_POINTER_JUMP - 3'd1;
            end
            CABE_OP_RELATIVE_BRANCH: begin
               pend_pc_next = ret_addr + target_i;
               wait_next = CABE_CYC_RELATIVE_BRANCH - 3'd1;
            end
            CABE_OP_JMP: begin
               pend_pc_next = target_i;
               wait_next = CABE_CYC_JMP - 3'd1;
            end
            CABE_OP_RELATIVE_SUBROUTINE_ENTRY, CABE_OP_POINTER_SUBROUTINE_ENTRY, CABE_OP_CALL: begin
               stack_we = 1'b1;
               sp_next = sp_reg - 16'd1;
               if (exec_op_i == CABE_OP_RELATIVE_SUBROUTINE_ENTRY) begin
                  pend_pc_next = ret_addr + target_i;
                  wait_next = CABE_CYC_RELATIVE_SUBROUTINE_ENTRY - 3'd1;
               end else if (exec_op_i == CABE_OP_POINTER_SUBROUTINE_ENTRY) begin
                  pend_pc_next = z_ptr;
                  wait_next = CABE_CYC_POINTER_SUBROUTINE_ENTRY - 3'd1;
               end else begin
                  stack_next_val = pc_reg + 16'd2; // two-word call returns past its own second word
                  pend_pc_next = target_i;
                  wait_next = CABE_CYC_CALL - 3'd1;
               end
            end
            CABE_OP_RET, CABE_OP_INTERRUPT_EXIT: begin
               sp_next = sp_reg + 16'd1;
               pend_pc_next = stack_reg[sp_reg[$clog2(STACK_DEPTH)-1:0] + 1'b1];
               wait_next = CABE_CYC_RET - 3'd1;
               if (exec_op_i == CABE_OP_INTERRUPT_EXIT) begin
                  sreg_next[CABE_FLAG_I] = 1'b1;
               end
            end
            CABE_OP_EQUAL_COMPARE_SKIP, CABE_OP_SKBC: begin
               // skip cost: one extra cycle per skipped word
               if ((exec_op_i == CABE_OP_EQUAL_COMPARE_SKIP && alu_a == alu_b) ||
                   (exec_op_i == CABE_OP_SKBC && !alu_b[bit_sel_i])) begin
                  pend_pc_next = pc_reg + (next_is_long_i ? 16'd3 : 16'd2);
                  wait_next = next_is_long_i ? 3'd2 : 3'd1;
               end
            end
            default: pend_pc_next = ret_addr;
         endcase
         if (wait_next == 3'd0) begin
            pc_next = pend_pc_next;
         end else begin
            busy_next = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state registers; the stack array has no reset to stay a plain memory
   always_ff @(posedge clk_sys_i or negedge rst_sync_reg) begin
      if (!rst_sync_reg) begin
         for (int i = 0; i < 32; i++) begin
            regs_reg[i] <= 8'h00;
         end
         sreg_reg <= CABE_SREG_RST;
         pc_reg <= CABE_PC_RST;
         sp_reg <= CABE_SP_RST;
         result_reg <= 8'h00;
         wait_reg <= 3'd0;
         busy_reg <= 1'b0;
         pend_pc_reg <= CABE_PC_RST;
      end else begin
         for (int i = 0; i < 32; i++) begin
            regs_reg[i] <= regs_next[i];
         end
         sreg_reg <= sreg_next;
         pc_reg <= pc_next;
         sp_reg <= sp_next;
         result_reg <= result_next;
         wait_reg <= wait_next;
         busy_reg <= busy_next;
         pend_pc_reg <= pend_pc_next;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (stack_we) begin
         stack_reg[sp_reg[$clog2(STACK_DEPTH)-1:0]] <= stack_next_val;
      end
   end

   assign busy_o = busy_reg;
   assign pc_o = pc_reg;
   assign sreg_o = sreg_reg;
   assign result_o = result_reg;
endmodule

/* testbench/cabe_core_monitor.sv */
/*
 * port-level checker for cabe_core: cycle spans, pc targets and flag keeping.
 * assumes it is bound to every cabe_core instance and sees only its ports.
 */
module cabe_core_monitor
   import cabe_pkg::*;
#(
   parameter int STACK_DEPTH = 256
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic exec_valid_i,
   input wire cabe_op_e exec_op_i,
   input wire logic [4:0] dst_sel_i,
   input wire logic [4:0] src_sel_i,
   input wire logic [7:0] imm_i,
   input wire logic [2:0] bit_sel_i,
   input wire logic [15:0] target_i,
   input wire logic next_is_long_i,
   input wire logic busy_o,
   input wire logic [15:0] pc_o,
   input wire logic [7:0] sreg_o,
   input wire logic [7:0] result_o
);
   logic acc;
   // an op is only taken on an edge where the core is idle
   assign acc = exec_valid_i && !busy_o;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////////////
   a_byte_op_single:
      assert property (acc && exec_op_i inside {CABE_OP_ADD, CABE_OP_ADC, CABE_OP_SUB,
         CABE_OP_SBB} |=> !busy_o && pc_o == $past(pc_o) + 16'h0001) else $error("byte op span");
   a_word_two_cycle:
      assert property (acc && exec_op_i inside {CABE_OP_WADD, CABE_OP_WSUB} |=> busy_o ##1
         (!busy_o && pc_o == $past(pc_o, 2) + 16'h0001)) else $error("word op span");
   // logic ops must leave carry and half carry alone, whatever the result
   a_logic_keeps_carry:
      assert property (acc && exec_op_i inside {CABE_OP_AND, CABE_OP_BITWISE_CONJUNCTION_IMM, CABE_OP_OR,
         CABE_OP_ORI, CABE_OP_XOR, CABE_OP_SETM, CABE_OP_CLRM, CABE_OP_TST} |=>
         (sreg_o & 8'h21) == ($past(sreg_o) & 8'h21) && !sreg_o[CABE_FLAG_V] &&
         sreg_o[CABE_FLAG_N] == result_o[7] && sreg_o[CABE_FLAG_Z] == (result_o == 8'h00))
      else $error("logic flags");
   a_ptr_jump_span:
      assert property (acc && exec_op_i == CABE_OP_POINTER_JUMP |=> busy_o ##1 !busy_o)
      else $error("pointer jump span");
   a_rel_call_target:
      assert property (acc && exec_op_i == CABE_OP_RELATIVE_SUBROUTINE_ENTRY |=> busy_o[*3] ##1 (!busy_o &&
         pc_o == $past(pc_o, 4) + 16'h0001 + $past(target_i, 4))) else $error("rel call");
   a_ptr_call_span:
      assert property (acc && exec_op_i == CABE_OP_POINTER_SUBROUTINE_ENTRY |=> busy_o[*3] ##1 !busy_o)
      else $error("pointer call span");
   a_abs_call_target:
      assert property (acc && exec_op_i == CABE_OP_CALL |=> busy_o[*4] ##1 (!busy_o &&
         pc_o == $past(target_i, 5) && sreg_o == $past(sreg_o, 5))) else $error("abs call");
   a_skip_keeps_flags:
      assert property (acc && exec_op_i inside {CABE_OP_EQUAL_COMPARE_SKIP, CABE_OP_SKBC} |=>
         sreg_o == $past(sreg_o)) else $error("skip changed flags");
   a_compare_one_cycle:
      assert property (acc && exec_op_i == CABE_OP_CPI |=> !busy_o &&
         sreg_o[CABE_FLAG_Z] == (result_o == 8'h00)) else $error("compare");
   a_abs_jump_target:
      assert property (acc && exec_op_i == CABE_OP_JMP |=> busy_o[*2] ##1 (!busy_o &&
         pc_o == $past(target_i, 3))) else $error("abs jump");
   a_return_span:
      assert property (acc && exec_op_i inside {CABE_OP_RET, CABE_OP_INTERRUPT_EXIT} |=> busy_o[*4]
         ##1 !busy_o) else $error("return span");
   a_interrupt_exit_sets_enable:
      assert property (acc && exec_op_i == CABE_OP_INTERRUPT_EXIT |-> ##5 sreg_o[CABE_FLAG_I])
      else $error("interrupt enable not set");
   cover property (acc && exec_op_i == CABE_OP_CALL);
   cover property (acc && exec_op_i == CABE_OP_EQUAL_COMPARE_SKIP && next_is_long_i);
   cover property (acc && exec_op_i == CABE_OP_INTERRUPT_EXIT);
endmodule

bind cabe_core cabe_core_monitor #(.STACK_DEPTH(STACK_DEPTH)) cabe_core_monitor_inst (
   .clk_sys_i(clk_sys_i),
   .rst_n_i(rst_n_i),
   .exec_valid_i(exec_valid_i),
   .exec_op_i(exec_op_i),
   .dst_sel_i(dst_sel_i),
   .src_sel_i(src_sel_i),
   .imm_i(imm_i),
   .bit_sel_i(bit_sel_i),
   .target_i(target_i),
   .next_is_long_i(next_is_long_i),
   .busy_o(busy_o),
   .pc_o(pc_o),
   .sreg_o(sreg_o),
   .result_o(result_o)
);

/* testbench/tb_cpu_alu_branch_execution.sv */
/*
 * self-checking bench for cabe_core: arithmetic, logic, word, flow and skip ops.
 * assumes registers read zero after reset; values are built with or-immediate.
 */
module tb_cpu_alu_branch_execution
   import cabe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, exec_valid_i = 1'b0, next_is_long_i = 1'b0;
   cabe_op_e exec_op_i = CABE_OP_NOP;
   logic [4:0] dst_sel_i = 5'h00, src_sel_i = 5'h00;
   logic [7:0] imm_i = 8'h00, sr = 8'h00, xr, msk = 8'hEF, sreg_o, result_o;
   logic [2:0] bit_sel_i = 3'h0;
   logic [15:0] target_i = 16'h0000, xpc = 16'h0000, pc_o;
   logic busy_o;
   logic [15:0] stk[$];
   int error_cnt = 0, total_checks = 0;
   cabe_core cabe_core_inst (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .exec_valid_i(exec_valid_i),
      .exec_op_i(exec_op_i),
      .dst_sel_i(dst_sel_i),
      .src_sel_i(src_sel_i),
      .imm_i(imm_i),
      .bit_sel_i(bit_sel_i),
      .target_i(target_i),
      .next_is_long_i(next_is_long_i),
      .busy_o(busy_o),
      .pc_o(pc_o),
      .sreg_o(sreg_o),
      .result_o(result_o)
   );
   // clock of 20 ns period
   initial begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // valid is held through busy, so every multi-cycle op also probes refusal
   task automatic ex(input cabe_op_e op, input logic [4:0] d, s, input logic [7:0] k,
      input logic [15:0] t, input int n, input logic [15:0] npc);
      int cyc;
      @(negedge clk_sys_i);
      exec_op_i = op;
      dst_sel_i = d;
      src_sel_i = s;
      imm_i = k;
      target_i = t;
      exec_valid_i = 1'b1;
      @(negedge clk_sys_i);
      cyc = 1;
      while (busy_o === 1'b1 && cyc < 9) begin
         @(negedge clk_sys_i);
         cyc++;
      end
      exec_valid_i = 1'b0;
      chk(16'(cyc), 16'(n));
      chk(pc_o, npc);
      chk(16'(sreg_o & msk), 16'(sr & msk));
      xpc = npc;
   endtask
   task automatic b(input cabe_op_e op, input logic [4:0] d, s, input logic [7:0] k);
      ex(op, d, s, k, 16'h0000, 1, xpc + 16'h0001);
      chk(16'(result_o), 16'(xr));
   endtask
   // expected byte add or subtract result and flags
   task automatic ar(input bit sb, input logic [7:0] a, c, input logic ci);
      logic [8:0] r;
      r = sb ? {1'b0, a} - {1'b0, c} - 9'(ci) : {1'b0, a} + {1'b0, c} + 9'(ci);
      xr = r[7:0];
      sr[0] = r[8];
      sr[1] = (xr == 8'h00);
      sr[2] = xr[7];
      sr[3] = sb ? (a[7] & ~c[7] & ~xr[7]) | (~a[7] & c[7] & xr[7])
                 : (a[7] & c[7] & ~xr[7]) | (~a[7] & ~c[7] & xr[7]);
      sr[5] = sb ? (~a[3] & c[3]) | (c[3] & xr[3]) | (xr[3] & ~a[3])
                 : (a[3] & c[3]) | (c[3] & ~xr[3]) | (~xr[3] & a[3]);
   endtask
   task automatic lg(input logic [7:0] r);
      xr = r;
      sr[1] = (r == 8'h00);
      sr[2] = r[7];
      sr[3] = 1'b0;
   endtask
   task automatic wd(input bit sb, input logic [15:0] a, input logic [7:0] k);
      logic [16:0] r;
      r = sb ? {1'b0, a} - 17'(k) : {1'b0, a} + 17'(k);
      sr[0] = r[16];
      sr[1] = (r[15:0] == 16'h0000);
      sr[2] = r[15];
      sr[3] = sb ? a[15] & ~r[15] : ~a[15] & r[15];
      sr[4] = sr[2] ^ sr[3];
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_arith();
      lg(8'h3C); b(CABE_OP_ORI, 5'h01, 5'h00, 8'h3C);
      lg(8'hC5); b(CABE_OP_ORI, 5'h02, 5'h00, 8'hC5);
      ar(0, 8'h3C, 8'hC5, 0); b(CABE_OP_ADD, 5'h01, 5'h02, 8'h00);
      ar(0, 8'h01, 8'hC5, sr[0]); b(CABE_OP_ADC, 5'h01, 5'h02, 8'h00);
      ar(1, 8'hC5, 8'hC7, 0); b(CABE_OP_SUB, 5'h02, 5'h01, 8'h00);
      ar(1, 8'hC7, 8'hFE, sr[0]); b(CABE_OP_SBB, 5'h01, 5'h02, 8'h00);
      ar(1, 8'hC8, 8'hC9, 0); b(CABE_OP_CPI, 5'h01, 5'h00, 8'hC9);
   endtask
   // carry and half carry are both set here, so logic ops must keep them
   task automatic t_logic();
      lg(8'hC8); b(CABE_OP_TST, 5'h01, 5'h01, 8'h00);
      lg(8'hC8); b(CABE_OP_AND, 5'h01, 5'h02, 8'h00);
      lg(8'h0E); b(CABE_OP_BITWISE_CONJUNCTION_IMM, 5'h02, 5'h00, 8'h0F);
      lg(8'hCE); b(CABE_OP_OR, 5'h01, 5'h02, 8'h00);
      lg(8'h00); b(CABE_OP_XOR, 5'h01, 5'h01, 8'h00);
      lg(8'hA0); b(CABE_OP_SETM, 5'h03, 5'h00, 8'hA0);
      lg(8'h80); b(CABE_OP_CLRM, 5'h03, 5'h00, 8'h20);
      lg(8'h80); b(CABE_OP_TST, 5'h03, 5'h03, 8'h00);
      lg(8'hF1); sr[0] = 1'b1; b(CABE_OP_COM, 5'h02, 5'h00, 8'h00);
      ar(1, 8'h00, 8'h80, 0); b(CABE_OP_NEG, 5'h03, 5'h00, 8'h00);
   endtask
   task automatic t_word();
      lg(8'hFF); b(CABE_OP_ORI, 5'h04, 5'h00, 8'hFF);
      lg(8'h7F); b(CABE_OP_ORI, 5'h05, 5'h00, 8'h7F);
      msk = 8'hDF;
      wd(0, 16'h7FFF, 8'h01);
      ex(CABE_OP_WADD, 5'h04, 5'h00, 8'h01, 16'h0000, 2, xpc + 16'h0001);
      msk = 8'hEF;
      lg(8'h80); b(CABE_OP_TST, 5'h05, 5'h05, 8'h00);
      lg(8'h00); b(CABE_OP_TST, 5'h04, 5'h04, 8'h00);
      msk = 8'hDF;
      wd(1, 16'h8000, 8'h01);
      ex(CABE_OP_WSUB, 5'h04, 5'h00, 8'h01, 16'h0000, 2, xpc + 16'h0001);
      msk = 8'hEF;
      lg(8'h7F); b(CABE_OP_TST, 5'h05, 5'h05, 8'h00);
   endtask
   task automatic t_flow();
      lg(8'h34); b(CABE_OP_ORI, 5'h1E, 5'h00, 8'h34);
      lg(8'h12); b(CABE_OP_ORI, 5'h1F, 5'h00, 8'h12);
      ex(CABE_OP_POINTER_JUMP, 5'h00, 5'h00, 8'h00, 16'h0000, 2, 16'h1234);
      ex(CABE_OP_RELATIVE_BRANCH, 5'h00, 5'h00, 8'h00, 16'h0010, 2, xpc + 16'h0011);
      ex(CABE_OP_JMP, 5'h00, 5'h00, 8'h00, 16'h0200, 3, 16'h0200);
      stk.push_back(xpc + 16'h0001);
      ex(CABE_OP_RELATIVE_SUBROUTINE_ENTRY, 5'h00, 5'h00, 8'h00, 16'hFFF0, 4, xpc - 16'h000F);
      stk.push_back(xpc + 16'h0001);
      ex(CABE_OP_POINTER_SUBROUTINE_ENTRY, 5'h00, 5'h00, 8'h00, 16'h0000, 4, 16'h1234);
      stk.push_back(xpc + 16'h0002);
      ex(CABE_OP_CALL, 5'h00, 5'h00, 8'h00, 16'h0300, 5, 16'h0300);
      ex(CABE_OP_RET, 5'h00, 5'h00, 8'h00, 16'h0000, 5, stk.pop_back());
      ex(CABE_OP_RET, 5'h00, 5'h00, 8'h00, 16'h0000, 5, stk.pop_back());
      sr[CABE_FLAG_I] = 1'b1;
      ex(CABE_OP_INTERRUPT_EXIT, 5'h00, 5'h00, 8'h00, 16'h0000, 5, stk.pop_back());
   endtask
   // r4 holds 0xFF and r5 holds 0x7F from the word scenario
   task automatic t_skip();
      ex(CABE_OP_EQUAL_COMPARE_SKIP, 5'h04, 5'h05, 8'h00, 16'h0000, 1, xpc + 16'h0001);
      ex(CABE_OP_EQUAL_COMPARE_SKIP, 5'h04, 5'h04, 8'h00, 16'h0000, 2, xpc + 16'h0002);
      next_is_long_i = 1'b1;
      ex(CABE_OP_EQUAL_COMPARE_SKIP, 5'h04, 5'h04, 8'h00, 16'h0000, 3, xpc + 16'h0003);
      bit_sel_i = 3'h7;
      ex(CABE_OP_SKBC, 5'h00, 5'h05, 8'h00, 16'h0000, 3, xpc + 16'h0003);
      bit_sel_i = 3'h0;
      ex(CABE_OP_SKBC, 5'h00, 5'h05, 8'h00, 16'h0000, 1, xpc + 16'h0001);
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // the whole sequence needs about 140 cycles
   initial begin
      repeat (5000) @(posedge clk_sys_i);
      error_cnt++;
      complete_run();
   end
   initial begin
      repeat (20) @(negedge clk_sys_i);
      rst_n_i = 1'b1;
      repeat (3) @(negedge clk_sys_i);
      chk(pc_o, CABE_PC_RST);
      chk(16'(sreg_o), 16'(CABE_SREG_RST));
      chk(16'(busy_o), 16'h0000);
      t_arith();
      t_logic();
      t_word();
      t_flow();
      t_skip();
      complete_run();
   end
endmodule
